// ==== design/axs_pkg.sv ====
// Purpose: constants and types for the accumulator exchange, stack and add datapath
// Assumes: 8-bit data, byte-wide data memory, one core clock
// Notes: the operation codes are the sequencer's, not the instruction encoding
//
// Operation
// [RULE1] swap: memory gets old accumulator, accumulator gets old memory, flags kept.
// [RULE2] save: flags and accumulator stored at stack_ptr, then stack_ptr plus 2.
// [RULE3] restore: stack_ptr minus 2 first, then flags and accumulator reloaded.
// [RULE4] add immediate: accumulator gets sum, four flags updated.
// [RULE5] add memory into accumulator, four flags updated.
// [RULE6] add into memory byte, accumulator kept, four flags updated.
// [RULE7] add with carry into accumulator, four flags updated.
// [RULE8] add with carry into memory byte, four flags updated.
// [RULE9] software saves at interrupt entry and restores before interrupt return.
// [RULE10] carry from bit 7, half carry from bit 3, signed overflow, zero.
// [RULE11] all values 8 bits; sums wrap, lost bit only in carry.
package axs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FLAG_W = 4;
    // flag register bit positions
    localparam int FLAG_ZERO = 0;
    localparam int FLAG_CARRY = 1;
    localparam int FLAG_HALF = 2;
    localparam int FLAG_SWRAP = 3;
    localparam int HALF_BIT = 4;
    localparam int SIGN_BIT = 7;
    localparam logic [ADDR_W-1:0] STACK_STEP = 8'h02;
    localparam logic [ADDR_W-1:0] STACK_HI_OFS = 8'h01;
    localparam logic [ADDR_W-1:0] SP_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;

    typedef enum logic [3:0] {
        AXS_OP_NONE = 4'h0,
        AXS_OP_SWAP = 4'h1,
        AXS_OP_SAVE = 4'h2,
        AXS_OP_RESTORE = 4'h3,
        AXS_OP_ADD_IMM = 4'h4,
        AXS_OP_ADD_TO_ACC = 4'h5,
        AXS_OP_ADD_TO_MEM = 4'h6,
        AXS_OP_ADC_TO_ACC = 4'h7,
        AXS_OP_ADC_TO_MEM = 4'h8
    } axs_op_e;

    // gray path: idle -> read -> write, one bit per step
    typedef enum logic [1:0] {
        AXS_ST_IDLE = 2'b00,
        AXS_ST_READ = 2'b01,
        AXS_ST_READ2 = 2'b10,
        AXS_ST_WRITE = 2'b11
    } axs_state_e;
endpackage

// ==== design/axs_core.sv ====
// Purpose: executes swap, save/restore of accumulator and flags, and additions
// Assumes: data memory answers a read in the cycle after mem_rd is high
// Notes: op_valid is taken only while op_ready is high
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module axs_core (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire axs_pkg::axs_op_e op_code,
    input wire logic [axs_pkg::ADDR_W-1:0] op_addr,
    input wire logic [axs_pkg::DATA_W-1:0] op_imm,
    output logic op_ready,
    output logic op_done,
    output logic mem_rd,
    output logic mem_wr,
    output logic [axs_pkg::ADDR_W-1:0] mem_addr,
    output logic [axs_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [axs_pkg::DATA_W-1:0] mem_rdata,
    output logic [axs_pkg::DATA_W-1:0] acc,
    output logic [axs_pkg::FLAG_W-1:0] flags,
    output logic [axs_pkg::ADDR_W-1:0] stack_ptr
);
    import axs_pkg::*;

    // ****************************************
    // adder with flags
    // ****************************************
    function automatic logic [DATA_W+FLAG_W-1:0] add_flags(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic cin
    );
        logic [DATA_W:0] full;
        logic [HALF_BIT:0] low;
        logic [FLAG_W-1:0] f;
        full = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin}; // RULE11
        low = {1'b0, a[HALF_BIT-1:0]} + {1'b0, b[HALF_BIT-1:0]} + {{HALF_BIT{1'b0}}, cin};
        f[FLAG_ZERO] = (full[DATA_W-1:0] == '0); // RULE10
        f[FLAG_CARRY] = full[DATA_W]; // RULE10
        f[FLAG_HALF] = low[HALF_BIT]; // RULE10
        f[FLAG_SWRAP] = (a[SIGN_BIT] == b[SIGN_BIT]) && (full[SIGN_BIT] != a[SIGN_BIT]); // RULE10
        return {f, full[DATA_W-1:0]};
    endfunction

    // ****************************************
    // state and held operation
    // ****************************************
    axs_state_e state_q, state_d;
    axs_op_e op_q;
    logic rvalid_q;
    logic [DATA_W-1:0] imm_q;
    logic [DATA_W-1:0] acc_q, acc_d;
    logic [FLAG_W-1:0] flags_q, flags_d;
    logic [ADDR_W-1:0] sp_q, sp_d;
    logic [DATA_W-1:0] lo_q;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [ADDR_W-1:0] maddr_q, maddr_d;
    logic rd_q, rd_d, wr_q, wr_d, done_q, done_d;

    wire logic take = op_valid && (state_q == AXS_ST_IDLE);
    wire logic is_adc = (op_q == AXS_OP_ADC_TO_ACC) || (op_q == AXS_OP_ADC_TO_MEM);
    // read data stand only in the cycle after the strobe; immediate needs none,
    // restore issues its second read before the first answer arrives
    wire logic data_wait = !rvalid_q && (op_q != AXS_OP_ADD_IMM) && (op_q != AXS_OP_RESTORE);
    wire logic [DATA_W-1:0] add_b = (op_q == AXS_OP_ADD_IMM) ? imm_q : mem_rdata;
    wire logic [DATA_W+FLAG_W-1:0] sum_f = add_flags(acc_q, add_b, is_adc && flags_q[FLAG_CARRY]);
    wire logic [DATA_W-1:0] sum = sum_f[DATA_W-1:0];
    wire logic [FLAG_W-1:0] sum_flags = sum_f[DATA_W+FLAG_W-1:DATA_W];
    wire logic [ADDR_W-1:0] sp_down = sp_q - STACK_STEP; // RULE3

    assign op_ready = (state_q == AXS_ST_IDLE);
    assign op_done = done_q;
    assign mem_rd = rd_q;
    assign mem_wr = wr_q;
    assign mem_addr = maddr_q;
    assign mem_wdata = wdata_q;
    assign acc = acc_q;
    assign flags = flags_q;
    assign stack_ptr = sp_q;

    // ****************************************
    // sequencing
    // ****************************************
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        flags_d = flags_q;
        sp_d = sp_q;
        wdata_d = wdata_q;
        maddr_d = maddr_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        done_d = 1'b0;
        unique case (state_q)
            AXS_ST_IDLE: begin
                if (take) begin
                    unique case (op_code)
                        AXS_OP_NONE: begin
                            done_d = 1'b1;
                        end
                        AXS_OP_ADD_IMM: begin
                            // immediate operand needs no memory cycle
                            state_d = AXS_ST_READ;
                        end
                        AXS_OP_SAVE: begin
                            // low byte accumulator, high byte flags
                            maddr_d = sp_q; // RULE2
                            wdata_d = acc_q; // RULE2
                            wr_d = 1'b1;
                            state_d = AXS_ST_WRITE;
                        end
                        AXS_OP_RESTORE: begin
                            sp_d = sp_down; // RULE3
                            maddr_d = sp_down; // RULE3
                            rd_d = 1'b1;
                            state_d = AXS_ST_READ;
                        end
                        default: begin
                            maddr_d = op_addr;
                            rd_d = 1'b1;
                            state_d = AXS_ST_READ;
                        end
                    endcase
                end
            end
            AXS_ST_READ: begin
                if (data_wait) begin
                    // stale bus this cycle; taking it would corrupt acc and flags
                    state_d = AXS_ST_READ;
                end else begin
                    state_d = AXS_ST_IDLE;
                    done_d = 1'b1;
                    unique case (op_q)
                        AXS_OP_SWAP: begin
                            acc_d = mem_rdata; // RULE1
                            wdata_d = acc_q; // RULE1
                            wr_d = 1'b1;
                            done_d = 1'b0;
                            state_d = AXS_ST_WRITE;
                        end
                        AXS_OP_RESTORE: begin
                            maddr_d = maddr_q + STACK_HI_OFS;
                            rd_d = 1'b1;
                            done_d = 1'b0;
                            state_d = AXS_ST_READ2;
                        end
                        AXS_OP_ADD_IMM, AXS_OP_ADD_TO_ACC, AXS_OP_ADC_TO_ACC: begin
                            acc_d = sum; // RULE4 RULE5 RULE7
                            flags_d = sum_flags; // RULE4 RULE5 RULE7
                        end
                        AXS_OP_ADD_TO_MEM, AXS_OP_ADC_TO_MEM: begin
                            wdata_d = sum; // RULE6 RULE8
                            flags_d = sum_flags; // RULE6 RULE8
                            wr_d = 1'b1;
                            done_d = 1'b0;
                            state_d = AXS_ST_WRITE;
                        end
                        default: ;
                    endcase
                end
            end
            AXS_ST_READ2: begin
                // first cycle brings the low byte, second the high byte
                if (!rd_q) begin
                    acc_d = lo_q; // RULE3
                    flags_d = mem_rdata[FLAG_W-1:0]; // RULE3
                    done_d = 1'b1;
                    state_d = AXS_ST_IDLE;
                end
            end
            AXS_ST_WRITE: begin
                if (op_q == AXS_OP_SAVE && maddr_q == sp_q) begin
                    maddr_d = sp_q + STACK_HI_OFS;
                    wdata_d = {{(DATA_W-FLAG_W){1'b0}}, flags_q}; // RULE2
                    wr_d = 1'b1;
                    sp_d = sp_q + STACK_STEP; // RULE2
                end else begin
                    done_d = 1'b1;
                    state_d = AXS_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= AXS_ST_IDLE;
            op_q <= AXS_OP_NONE;
            rvalid_q <= 1'b0;
            imm_q <= '0;
            acc_q <= ACC_RESET;
            flags_q <= FLAGS_RESET;
            sp_q <= SP_RESET;
            lo_q <= '0;
            wdata_q <= '0;
            maddr_q <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            sp_q <= sp_d;
            wdata_q <= wdata_d;
            maddr_q <= maddr_d;
            rd_q <= rd_d;
            rvalid_q <= rd_q;
            wr_q <= wr_d;
            done_q <= done_d;
            if (take) begin
                op_q <= op_code;
                imm_q <= op_imm;
            end
            // capture the low stack byte while the high one is fetched
            if ((state_q == AXS_ST_READ2) && rd_q) begin
                lo_q <= mem_rdata;
            end
        end
    end
endmodule // axs_core
`default_nettype wire

// ==== dv/axs_mem_model.sv ====
// Purpose: data memory partner for axs_core
// Assumes: read data valid only in the cycle after mem_rd
// Notes: idle read bus toggles so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module axs_mem_model (
    input wire logic core_clk,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [256];
    initial mem_rdata = 8'h5A;
    always @(posedge core_clk) begin
        if (mem_wr) mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule // axs_mem_model
`default_nettype wire

// ==== dv/axs_core_checker.sv ====
// Purpose: port-level assertions for axs_core
// Assumes: one clock, synchronous reset
// Notes: timing follows the hand-over walk
`timescale 1ns/1ps
`default_nettype none
module axs_core_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire axs_pkg::axs_op_e op_code,
    input wire logic [7:0] op_addr,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] acc,
    input wire logic [3:0] flags,
    input wire logic [7:0] stack_ptr
);
    import axs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic take = op_valid && op_ready;
    sequence wr_low;
        mem_wr && mem_addr == $past(stack_ptr) && mem_wdata == $past(acc);
    endsequence
    sequence wr_high;
        mem_wr && mem_addr == $past(stack_ptr, 2) + 8'h01 && mem_wdata == {4'h0, $past(flags, 2)};
    endsequence
    a_done_idle: assert property (op_done |-> op_ready) else $error("done while busy");
    a_one_strobe: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
    a_busy_refuse: assert property (take && op_code != AXS_OP_NONE |=> !op_ready)
        else $error("ready while busy");
    a_imm_timing: assert property (take && op_code == AXS_OP_ADD_IMM |=> !op_done ##1 op_done)
        else $error("add imm timing");
    a_acc_fetch: assert property (take && op_code == AXS_OP_ADD_TO_ACC
        |=> mem_rd && mem_addr == $past(op_addr) ##2 op_done) else $error("add fetch");
    a_save_order: assert property (take && op_code == AXS_OP_SAVE
        |=> wr_low ##1 wr_high ##1 op_done && stack_ptr == $past(stack_ptr, 3) + 8'h02)
        else $error("save order");
    a_restore_reads: assert property (take && op_code == AXS_OP_RESTORE
        |=> mem_rd && mem_addr == $past(stack_ptr) - 8'h02 && stack_ptr == mem_addr
        ##1 mem_rd && mem_addr == $past(stack_ptr, 2) - 8'h01) else $error("restore reads");
    a_flags_kept: assert property (take && op_code inside {AXS_OP_SWAP, AXS_OP_SAVE}
        |=> ($stable(flags)) [*3]) else $error("flags changed");
endmodule // axs_core_checker
bind axs_core axs_core_checker axs_core_checker_i (.core_clk, .sys_rst, .op_valid, .op_code,
    .op_addr, .op_ready, .op_done, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .acc, .flags,
    .stack_ptr);
`default_nettype wire

// ==== dv/axs_core_test.sv ====
// Purpose: self-checking bench for axs_core
// Assumes: memory model answers reads one cycle late
// Notes: bench mirrors acc, flags and stack_ptr
`timescale 1ns/1ps
`default_nettype none
module axs_core_test;
    import axs_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    axs_op_e op_code = AXS_OP_NONE;
    logic [7:0] op_addr = 8'h00;
    logic [7:0] op_imm = 8'h00;
    logic op_ready, op_done, mem_rd, mem_wr;
    logic [7:0] mem_addr, mem_wdata, mem_rdata, acc, stack_ptr, am, spm;
    logic [3:0] flags, fm;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    axs_core axs_core_i (.core_clk, .sys_rst, .op_valid, .op_code, .op_addr, .op_imm, .op_ready,
        .op_done, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .acc, .flags, .stack_ptr);
    axs_mem_model axs_mem_model_i (.core_clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
    initial forever #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] mm(logic [7:0] a);
        return axs_mem_model_i.mem[a];
    endfunction
    function automatic logic [11:0] addf(logic [7:0] a, b, logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        return {a[7] == b[7] && s[7] != a[7], h[4], s[8], s[7:0] == 8'h00, s[7:0]};
    endfunction
    task automatic chk(string n, logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic do_op(axs_op_e op, logic [7:0] ad, im);
        logic [7:0] m;
        logic [11:0] s;
        logic [31:0] e;
        logic tm;
        m = mm(ad);
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= op;
        op_addr <= ad;
        op_imm <= im;
        @(posedge core_clk);
        op_valid <= 1'b0;
        // bounded wait: done must come within a few cycles
        repeat (6) begin
            #1;
            if (op_done === 1'b1) break;
            @(posedge core_clk);
        end
        chk("done", {31'h0, op_done}, 32'h1);
        case (op)
            AXS_OP_NONE: begin
                chk("none", {12'h0, flags, acc, stack_ptr}, {12'h0, fm, am, spm});
            end
            AXS_OP_SWAP: begin
                chk("swap", {12'h0, flags, acc, mm(ad)}, {12'h0, fm, m, am});
                am = m;
            end
            AXS_OP_SAVE: begin
                e = {4'h0, fm, spm + 8'h02, 4'h0, fm, am};
                chk("save", {4'h0, flags, stack_ptr, mm(spm + 8'h01), mm(spm)}, e);
                spm = spm + 8'h02;
            end
            AXS_OP_RESTORE: begin
                spm = spm - 8'h02;
                am = mm(spm);
                fm = 4'(mm(spm + 8'h01));
                chk("restore", {12'h0, stack_ptr, flags, acc}, {12'h0, spm, fm, am});
            end
            default: begin
                tm = op == AXS_OP_ADD_TO_MEM || op == AXS_OP_ADC_TO_MEM;
                s = addf(am, op == AXS_OP_ADD_IMM ? im : m,
                    fm[1] & (tm ? op == AXS_OP_ADC_TO_MEM : op == AXS_OP_ADC_TO_ACC));
                e = {12'h0, s[11:8], tm ? am : s[7:0], tm ? s[7:0] : m};
                chk("add", {12'h0, flags, acc, mm(ad)}, e);
                fm = s[11:8];
                am = tm ? am : s[7:0];
            end
        endcase
    endtask
    task automatic t_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        am = 8'h00;
        fm = 4'h0;
        spm = 8'h00;
        chk("reset", {11'h0, op_ready, flags, acc, stack_ptr}, {11'h0, 1'b1, 20'h00000});
        $display("reset test done");
    endtask
    task automatic t_add();
        logic [7:0] v [8] = '{8'h0F, 8'h01, 8'h80, 8'h80, 8'h7F, 8'h01, 8'hFF, 8'hFF};
        // every add flavour on each operand pair, carry chaining between them
        for (int i = 0; i < 8; i += 2) begin
            axs_mem_model_i.mem[8'h20] = v[i];
            axs_mem_model_i.mem[8'h21] = v[i + 1];
            do_op(AXS_OP_SWAP, 8'h20, 8'h00);
            for (int k = 4; k < 9; k++) do_op(axs_op_e'(k), 8'h21, v[i + 1]);
        end
        $display("add test done");
    endtask
    task automatic t_swap();
        axs_mem_model_i.mem[8'h10] = 8'hA5;
        do_op(AXS_OP_SWAP, 8'h10, 8'h00);
        do_op(AXS_OP_NONE, 8'h10, 8'h00);
        do_op(AXS_OP_SWAP, 8'h10, 8'h00);
        $display("swap test done");
    endtask
    task automatic t_stack();
        // nested routines: save on entry, restore just before return
        do_op(AXS_OP_SAVE, 8'h00, 8'h00);
        do_op(AXS_OP_ADD_IMM, 8'h00, 8'h91);
        do_op(AXS_OP_SAVE, 8'h00, 8'h00);
        do_op(AXS_OP_RESTORE, 8'h00, 8'h00);
        do_op(AXS_OP_RESTORE, 8'h00, 8'h00);
        // pointer wraps below zero; crafted pair sets every flag
        axs_mem_model_i.mem[8'hFE] = 8'h00;
        axs_mem_model_i.mem[8'hFF] = 8'h0F;
        do_op(AXS_OP_RESTORE, 8'h00, 8'h00);
        $display("stack test done");
    endtask
    initial begin
        for (int i = 0; i < 256; i++) axs_mem_model_i.mem[i] = 8'(i);
        t_reset();
        t_add();
        t_swap();
        t_stack();
        t_reset();
        t_stack();
        tally_and_finish();
    end
endmodule // axs_core_test
`default_nettype wire
